// [verilog/rxs_irq_top.sv]
/*
 * receive interrupt block for a two-channel baseband: data registers,
 * condition detection, enable register and the interrupt request.
 * assumes a register port driven by the serial host interface, one
 * request a cycle, and correlator bit strobes synchronous to ref_clk.
 */
`default_nettype none
`include "rxs_cfg.svh"

module rxs_irq_top #(
   parameter int NUM_CH = `RXS_NUM_CH
) (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   output logic            reg_rvalid,
   // channel A correlator
   input  wire logic       rxa_tick,
   input  wire logic       rxa_ok,
   input  wire logic       rxa_bit,
   // channel B correlator
   input  wire logic       rxb_tick,
   input  wire logic       rxb_ok,
   input  wire logic       rxb_bit,
   // interrupt request
   output logic            irq
);
   // ------------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------------
   if (NUM_CH != `RXS_NUM_CH) begin : g_bad_ch
      $error("rxs_irq_top serves exactly %0d channels", `RXS_NUM_CH);
   end

   // ------------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------------
   // data register address of a channel
   function automatic logic [7:0] data_addr(input int ch);
      data_addr = (ch == 0) ? `RXS_ADDR_DATA_A : `RXS_ADDR_DATA_B;
   endfunction

   // true when a read or write hits the given address
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
      hit = (addr == target);
   endfunction

   // ------------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------------
   logic [7:0]        config_reg;
   logic [7:0]        serdes_ctl;
   logic [7:0]        receive_interrupt_enables;
   rxs_pkg::rxs_gap_t gap_len;
   logic              serdes_en;
   logic              rx_invert;

   assign gap_len   = serdes_ctl[`RXS_GAP_MSB:`RXS_GAP_LSB];
   assign serdes_en = serdes_ctl[`RXS_SERDES_EN_BIT];
   assign rx_invert = config_reg[`RXS_RX_INV_BIT];

   // writes; reserved bits are forced to zero by the masks
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         config_reg                <= `RXS_RST_CONFIG;
         serdes_ctl                <= `RXS_RST_SERDES;
         receive_interrupt_enables <= `RXS_RST_ENABLE;
      end else if (reg_wr) begin
         if (hit(reg_addr, `RXS_ADDR_CONFIG)) begin
            config_reg <= reg_wdata & `RXS_MASK_CONFIG;
         end
         if (hit(reg_addr, `RXS_ADDR_SERDES)) begin
            serdes_ctl <= reg_wdata & `RXS_MASK_SERDES;
         end
         if (hit(reg_addr, `RXS_ADDR_ENABLE)) begin
            receive_interrupt_enables <= reg_wdata;
         end
      end
   end

   // ------------------------------------------------------------------
   // receivers
   // ------------------------------------------------------------------
   logic [NUM_CH-1:0]  ch_tick;
   logic [NUM_CH-1:0]  ch_ok;
   logic [NUM_CH-1:0]  ch_bit;
   logic [NUM_CH-1:0]  ch_load;
   logic [NUM_CH-1:0]  ch_all_valid;
   logic [NUM_CH-1:0]  ch_eof;
   rxs_pkg::rxs_byte_t ch_byte [NUM_CH];

   // gather the pins; inversion applies to the bit value only
   assign ch_tick = {rxb_tick, rxa_tick};
   assign ch_ok   = {rxb_ok, rxa_ok};
   assign ch_bit  = {rxb_bit, rxa_bit} ^ {NUM_CH{rx_invert}};

   // ------------------------------------------------------------------
   // per-channel data register and condition flags
   // ------------------------------------------------------------------
   rxs_pkg::rxs_byte_t data_reg [NUM_CH];
   logic [NUM_CH-1:0]  full_flag;
   logic [NUM_CH-1:0]  valid_flag;
   logic [NUM_CH-1:0]  under_flag;
   logic [NUM_CH-1:0]  over_flag;
   logic [NUM_CH-1:0]  eof_flag;
   logic [NUM_CH-1:0]  data_rd;
   logic               status_rd;

   // status read clears the sticky flow and frame flags
   assign status_rd = reg_rd & hit(reg_addr, `RXS_ADDR_STATUS);

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         rxs_chan #(
            .BYTE_W (`RXS_BYTE_W)
         ) u_chan (
            .ref_clk        (ref_clk),
            .rst_n          (rst_n),
            .enable         (serdes_en),
            .gap_len        (gap_len),
            .bit_tick       (ch_tick[ch]),
            .bit_ok         (ch_ok[ch]),
            .bit_val        (ch_bit[ch]),
            .load           (ch_load[ch]),
            .load_byte      (ch_byte[ch]),
            .load_all_valid (ch_all_valid[ch]),
            .eof            (ch_eof[ch])
         );

         assign data_rd[ch] = reg_rd & hit(reg_addr, data_addr(ch));

         // data register takes every transfer from the receiver
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               data_reg[ch]   <= '0;
               valid_flag[ch] <= 1'b0;
            end else if (ch_load[ch]) begin
               data_reg[ch]   <= ch_byte[ch];
               valid_flag[ch] <= ch_all_valid[ch];
            end
         end

         // full follows the register contents; a new load beats a read
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               full_flag[ch] <= 1'b0;
            end else if (ch_load[ch]) begin
               full_flag[ch] <= 1'b1;
            end else if (data_rd[ch]) begin
               full_flag[ch] <= 1'b0;
            end
         end

         // overflow: load while the previous byte is still unread
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               over_flag[ch] <= 1'b0;
            end else if (ch_load[ch] && full_flag[ch] && !data_rd[ch]) begin
               over_flag[ch] <= 1'b1;
            end else if (status_rd) begin
               over_flag[ch] <= 1'b0;
            end
         end

         // underflow: read of an empty register; a same-cycle load does
         // not rescue the read because the old, empty value is returned
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               under_flag[ch] <= 1'b0;
            end else if (data_rd[ch] && !full_flag[ch]) begin
               under_flag[ch] <= 1'b1;
            end else if (status_rd) begin
               under_flag[ch] <= 1'b0;
            end
         end

         // end of frame holds until the status read; set wins the tie
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               eof_flag[ch] <= 1'b0;
            end else if (ch_eof[ch]) begin
               eof_flag[ch] <= 1'b1;
            end else if (status_rd) begin
               eof_flag[ch] <= 1'b0;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // pending conditions and status image
   // ------------------------------------------------------------------
   logic [7:0] pending;
   logic [7:0] status_img;

   // pending laid out exactly like the enable register
   always_comb begin
      pending = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         pending[i*`RXS_NIBBLE + `RXS_SLOT_FULL]  = full_flag[i];
         pending[i*`RXS_NIBBLE + `RXS_SLOT_EOF]   = eof_flag[i];
         pending[i*`RXS_NIBBLE + `RXS_SLOT_FLOW]  = over_flag[i];
         pending[i*`RXS_NIBBLE + `RXS_SLOT_UNDER] = under_flag[i];
      end
   end

   // status shows flags whether or not they are enabled
   always_comb begin
      status_img = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         status_img[i*`RXS_NIBBLE + `RXS_SLOT_FULL]  = full_flag[i];
         status_img[i*`RXS_NIBBLE + `RXS_SLOT_EOF]   = eof_flag[i];
         status_img[i*`RXS_NIBBLE + `RXS_SLOT_FLOW]  = over_flag[i] | under_flag[i];
         status_img[i*`RXS_NIBBLE + `RXS_SLOT_VALID] = valid_flag[i];
      end
   end

   // ------------------------------------------------------------------
   // interrupt request
   // ------------------------------------------------------------------
   // each enable bit gates its own condition, bit for bit:
   // 7 under B 6 over B 5 eof B 4 full B
   // 3 under A 2 over A 1 eof A 0 full A
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(pending & receive_interrupt_enables);
      end
   end

   // ------------------------------------------------------------------
   // read data path
   // ------------------------------------------------------------------
   // registered read; unmapped addresses return zero
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata  <= '0;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            case (reg_addr)
               `RXS_ADDR_CONFIG: reg_rdata <= config_reg;
               `RXS_ADDR_SERDES: reg_rdata <= serdes_ctl;
               `RXS_ADDR_ENABLE: reg_rdata <= receive_interrupt_enables;
               `RXS_ADDR_STATUS: reg_rdata <= status_img;
               `RXS_ADDR_DATA_A: reg_rdata <= data_reg[0];
               `RXS_ADDR_DATA_B: reg_rdata <= data_reg[1];
               default:          reg_rdata <= '0;
            endcase
         end
      end
   end
endmodule

`default_nettype wire

// [verilog/rxs_cfg.svh]
/*
 * constants for the two-channel receive interrupt block: register offsets,
 * field positions, reset values and sizes.
 * assumes it is included by bare name before any module that uses it.
 */
// Operation
// - enable bit 7 lets channel B underflow request an interrupt
// - reading empty channel B data register flags channel B underflow
// - enable bit 6 lets channel B overflow request an interrupt
// - new channel B byte loaded before previous read flags overflow
// - enable bit 5 lets channel B end of frame request an interrupt
// - channel B end of frame needs a valid bit, then gap exceeded
// - gap length zero ends frame at first invalid bit
// - end of frame stays pending until status register is read
// - enable bit 4 lets channel B full request an interrupt
// - channel B full on byte complete or end of frame partial byte
// - enable bit 3 lets channel A underflow request an interrupt
// - reading empty channel A data register flags channel A underflow
// - enable bit 2 lets channel A overflow request an interrupt
// - new channel A byte loaded before previous read flags overflow
// - enable bit 1 lets channel A end of frame request an interrupt
// - channel A end of frame needs a valid bit, then gap exceeded
// - enable bit 0 lets channel A full request an interrupt
// - channel A full on byte complete or end of frame partial byte
// - gap length is serializer control bits 2 to 0
`ifndef RXS_CFG_SVH
`define RXS_CFG_SVH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define RXS_ADDR_CONFIG  8'h05
`define RXS_ADDR_SERDES  8'h06
`define RXS_ADDR_ENABLE  8'h07
`define RXS_ADDR_STATUS  8'h08
`define RXS_ADDR_DATA_A  8'h09
`define RXS_ADDR_DATA_B  8'h0b

// ------------------------------------------------------------------
// reset values and writable masks
// ------------------------------------------------------------------
`define RXS_RST_CONFIG   8'h01
`define RXS_RST_SERDES   8'h03
`define RXS_RST_ENABLE   8'h00
`define RXS_MASK_CONFIG  8'h1b
`define RXS_MASK_SERDES  8'h0f

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define RXS_SERDES_EN_BIT 3
`define RXS_GAP_MSB       2
`define RXS_GAP_LSB       0
`define RXS_RX_INV_BIT    4
// condition slots inside one channel's nibble
`define RXS_SLOT_FULL     0
`define RXS_SLOT_EOF      1
`define RXS_SLOT_FLOW     2
`define RXS_SLOT_UNDER    3
`define RXS_SLOT_VALID    3

// ------------------------------------------------------------------
// sizes
// ------------------------------------------------------------------
`define RXS_NUM_CH        2
`define RXS_BYTE_W        8
`define RXS_GAP_W         3
`define RXS_NIBBLE        4

`endif

// [verilog/rxs_pkg.sv]
/*
 * types shared by the receive interrupt block.
 * assumes rxs_cfg.svh is available for widths.
 */
`default_nettype none
`include "rxs_cfg.svh"

package rxs_pkg;
   // one received byte
   typedef logic [`RXS_BYTE_W-1:0] rxs_byte_t;
   // end-of-frame gap length
   typedef logic [`RXS_GAP_W-1:0]  rxs_gap_t;
   // receiver framing state
   typedef enum logic {
      RXS_IDLE,
      RXS_FRAME
   } rxs_state_t;
endpackage

`default_nettype wire

// [verilog/rxs_chan.sv]
/*
 * one channel's byte assembler and end-of-frame detector.
 * assumes one bit_tick pulse per bit time, with bit_ok telling whether
 * the correlator found a valid bit in that time.
 */
`default_nettype none
`include "rxs_cfg.svh"

module rxs_chan #(
   parameter int BYTE_W = `RXS_BYTE_W
) (
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   // control
   input  wire logic              enable,
   input  wire rxs_pkg::rxs_gap_t gap_len,
   // correlator bits
   input  wire logic              bit_tick,
   input  wire logic              bit_ok,
   input  wire logic              bit_val,
   // towards the data register and end-of-frame flag
   output logic                   load,
   output rxs_pkg::rxs_byte_t     load_byte,
   output logic                   load_all_valid,
   output logic                   eof
);
   // ------------------------------------------------------------------
   // checks and state
   // ------------------------------------------------------------------
   if (BYTE_W != `RXS_BYTE_W) begin : g_bad_width
      $error("rxs_chan only serves %0d-bit bytes", `RXS_BYTE_W);
   end

   rxs_pkg::rxs_state_t state;
   rxs_pkg::rxs_byte_t  shift;
   logic [3:0]          bit_cnt;
   rxs_pkg::rxs_gap_t   inv_cnt;
   rxs_pkg::rxs_byte_t  next_shift;

   assign next_shift = {shift[BYTE_W-2:0], bit_val};

   // assembler: valid bits shift in msb first, invalid bits count the gap
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state          <= rxs_pkg::RXS_IDLE;
         shift          <= '0;
         bit_cnt        <= '0;
         inv_cnt        <= '0;
         load           <= 1'b0;
         load_byte      <= '0;
         load_all_valid <= 1'b0;
         eof            <= 1'b0;
      end else begin
         load <= 1'b0;
         eof  <= 1'b0;
         if (!enable) begin
            // partial byte dropped when serializer is switched off
            state   <= rxs_pkg::RXS_IDLE;
            bit_cnt <= '0;
            inv_cnt <= '0;
         end else if (bit_tick) begin
            case (state)
               rxs_pkg::RXS_IDLE: begin
                  if (bit_ok) begin
                     state   <= rxs_pkg::RXS_FRAME; // first valid bit opens frame
                     shift   <= next_shift;
                     bit_cnt <= 4'h1;
                     inv_cnt <= '0;
                  end
               end
               rxs_pkg::RXS_FRAME: begin
                  if (bit_ok) begin
                     inv_cnt <= '0;
                     if (bit_cnt == 4'(BYTE_W - 1)) begin
                        load           <= 1'b1; // complete byte
                        load_byte      <= next_shift;
                        load_all_valid <= 1'b1;
                        bit_cnt        <= '0;
                     end else begin
                        bit_cnt <= bit_cnt + 4'h1;
                     end
                     shift <= next_shift;
                  end else if (inv_cnt >= gap_len) begin
                     // this invalid bit makes the gap exceed the length
                     eof     <= 1'b1;
                     state   <= rxs_pkg::RXS_IDLE;
                     inv_cnt <= '0;
                     bit_cnt <= '0;
                     if (bit_cnt != 4'h0) begin
                        load           <= 1'b1; // partial byte moved at frame end
                        load_byte      <= shift;
                        load_all_valid <= 1'b0;
                     end
                  end else begin
                     inv_cnt <= inv_cnt + 3'h1;
                  end
               end
               default: state <= rxs_pkg::RXS_IDLE;
            endcase
         end
      end
   end
endmodule

`default_nettype wire

// [sim/rxs_irq_checker.sv]
/*
 * checker for the receive interrupt block: read answer, enable readback,
 * irq causes and the delay from frame events to the request.
 * assumes it is bound to rxs_irq_top and sees only its ports.
 */
`default_nettype none

module rxs_irq_checker (
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_rvalid,
   // correlators
   input wire logic       rxa_tick,
   input wire logic       rxa_ok,
   input wire logic       rxa_bit,
   input wire logic       rxb_tick,
   input wire logic       rxb_ok,
   input wire logic       rxb_bit,
   // request
   input wire logic       irq
);
   timeunit 1ns;
   timeprecision 1ps;

   // --------------------
   // shadow state
   // --------------------
   logic [7:0] en_sh;
   logic [7:0] sd_sh;
   logic [1:0] seen;
   logic [2:0] inv [2];
   logic [2:0] nb [2];
   logic [1:0] tk;
   logic [1:0] ok;
   logic [1:0] eofev;
   logic [1:0] fullev;

   assign tk = {rxb_tick, rxa_tick};
   assign ok = {rxb_ok, rxa_ok};

   // frame end and byte complete as the gap field counts them
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         eofev[c]  = sd_sh[3] && tk[c] && !ok[c] && seen[c] && inv[c] >= sd_sh[2:0];
         fullev[c] = eofev[c] || (sd_sh[3] && tk[c] && ok[c] && nb[c] == 3'h7);
      end
   end

   // register shadows
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         en_sh <= 8'h00;
         sd_sh <= 8'h03;
      end else if (reg_wr && reg_addr == 8'h07) begin
         en_sh <= reg_wdata;
      end else if (reg_wr && reg_addr == 8'h06) begin
         sd_sh <= reg_wdata & 8'h0f;
      end
   end

   // framing per channel; serializer off drops the frame
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         seen <= 2'b00;
         inv  <= '{3'h0, 3'h0};
         nb   <= '{3'h0, 3'h0};
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (!sd_sh[3] || eofev[c]) begin
               seen[c] <= 1'b0;
               inv[c]  <= 3'h0;
               nb[c]   <= 3'h0;
            end else if (tk[c] && ok[c]) begin
               seen[c] <= 1'b1;
               inv[c]  <= 3'h0;
               nb[c]   <= nb[c] + 3'h1;
            end else if (tk[c] && seen[c] && inv[c] != 3'h7) begin
               inv[c] <= inv[c] + 3'h1;
            end
         end
      end
   end

   // --------------------
   // properties
   // --------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // flag lands two edges after the cause, request one edge later
   sequence s_irq_late;
      ##3 irq;
   endsequence
   sequence s_enable_rd;
      reg_rd && reg_addr == 8'h07;
   endsequence

   AST_RD_ANSWER: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
   AST_RD_QUIET: assert property (!reg_rd |=> !reg_rvalid) else $error("spurious rvalid");
   AST_ENABLE_RB: assert property (s_enable_rd |=> reg_rdata == en_sh)
      else $error("enable readback wrong");
   AST_IRQ_GATE: assert property (irq |-> $past(en_sh) != 8'h00)
      else $error("irq with all enables off");
   AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(rxa_tick || rxb_tick, 3)
      || $past(reg_rd, 2) || $past(reg_rd, 3) || $past(reg_wr, 2)) else $error("irq without cause");
   AST_IRQ_HOLD: assert property ($fell(irq) |-> $past(reg_rd || reg_wr, 2))
      else $error("irq dropped without access");
   AST_EOF_A: assert property (eofev[0] && en_sh[1] |-> s_irq_late)
      else $error("end of frame A not requested");
   AST_EOF_B: assert property (eofev[1] && en_sh[5] |-> s_irq_late)
      else $error("end of frame B not requested");
   AST_FULL_A: assert property (fullev[0] && en_sh[0] |-> s_irq_late)
      else $error("full A not requested");
   AST_FULL_B: assert property (fullev[1] && en_sh[4] |-> s_irq_late)
      else $error("full B not requested");
endmodule

bind rxs_irq_top rxs_irq_checker chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .rxa_tick(rxa_tick), .rxa_ok(rxa_ok), .rxa_bit(rxa_bit),
   .rxb_tick(rxb_tick), .rxb_ok(rxb_ok), .rxb_bit(rxb_bit), .irq(irq));

`default_nettype wire

// [sim/rxs_host_model.sv]
/*
 * host model: register writes and reads, one strobe cycle each.
 * assumes the read answer comes exactly one cycle after the strobe.
 */
`default_nettype none

module rxs_host_model (
   // clock
   input wire logic        ref_clk,
   // register port
   output var logic [7:0]  reg_addr,
   output var logic [7:0]  reg_wdata,
   output var logic        reg_wr,
   output var logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        reg_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle bus at time zero
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   // released fields flip so stale values are never trusted
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
      reg_wdata <= ~d;
      reg_addr  <= ~a;
   endtask

   // data taken only with the answer strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      // answer taken at the edge where rvalid is seen high
      @(posedge ref_clk);
      d = reg_rvalid ? reg_rdata : 8'hxx;
   endtask
endmodule

`default_nettype wire

// [sim/tb.sv]
/*
 * testbench for the receive interrupt block: register reset values,
 * underflow, full, overflow and end of frame per channel, irq gating.
 * assumes the host model and checker files are compiled before it.
 */
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic       ref_clk, rst_n, reg_wr, reg_rd, reg_rvalid, irq;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v;
   logic       rxa_tick, rxa_ok, rxa_bit, rxb_tick, rxb_ok, rxb_bit;
   int         miscompares, checks;

   rxs_irq_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .rxa_tick(rxa_tick), .rxa_ok(rxa_ok), .rxa_bit(rxa_bit),
      .rxb_tick(rxb_tick), .rxb_ok(rxb_ok), .rxb_bit(rxb_bit), .irq(irq));
   rxs_host_model host_u (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   // 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // --------------------
   // helpers
   // --------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
      checks++;
      if ((got & m) !== (exp & m)) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
      host_u.rd(a, rd_v);
      chk(rd_v, exp, m);
   endtask

   // request lags its cause by three cycles at most
   task automatic ichk(input logic e);
      repeat (4) @(posedge ref_clk);
      #1;
      chk({7'h00, irq}, {7'h00, e}, 8'h01);
   endtask

   function automatic logic [7:0] dat(input int c);
      return (c == 0) ? 8'h09 : 8'h0b;
   endfunction

   function automatic logic [7:0] nib(input logic [7:0] v, input int c);
      return (c == 0) ? v : {v[3:0], 4'h0};
   endfunction

   // one bit time; the released bit line flips so stale values never count
   task automatic send_bit(input int c, input logic ok, input logic v);
      @(posedge ref_clk);
      if (c == 0) begin
         rxa_tick <= 1'b1;
         rxa_ok   <= ok;
         rxa_bit  <= v;
      end else begin
         rxb_tick <= 1'b1;
         rxb_ok   <= ok;
         rxb_bit  <= v;
      end
      @(posedge ref_clk);
      rxa_tick <= 1'b0;
      rxb_tick <= 1'b0;
      if (c == 0) rxa_bit <= ~v;
      else rxb_bit <= ~v;
   endtask

   task automatic send_byte(input int c, input logic [7:0] b);
      for (int i = 7; i >= 0; i--) send_bit(c, 1'b1, b[i]);
   endtask

   task automatic stop_test;
      if (miscompares == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // hang guard, far beyond the roughly 270 cycles the tests need
   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      stop_test();
   end

   // --------------------
   // tests
   // --------------------
   initial begin
      {rxa_tick, rxa_ok, rxa_bit, rxb_tick, rxb_ok, rxb_bit} = 6'h00;
      rst_n = 1'b0;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      rchk(8'h05, 8'h01, 8'hff);
      rchk(8'h06, 8'h03, 8'hff);
      rchk(8'h07, 8'h00, 8'hff);
      rchk(8'h08, 8'h00, 8'hff);
      rchk(8'h0f, 8'h00, 8'hff);
      host_u.wr(8'h07, 8'h5a);
      rchk(8'h07, 8'h5a, 8'hff);
      ichk(1'b0);
      host_u.wr(8'h06, 8'h08);
      // underflow: masked first, then let through
      for (int c = 0; c < 2; c++) begin
         host_u.wr(8'h07, 8'h00);
         host_u.rd(dat(c), rd_v);
         ichk(1'b0);
         host_u.wr(8'h07, nib(8'h08, c));
         ichk(1'b1);
         rchk(8'h08, nib(8'h04, c), nib(8'h0f, c));
         ichk(1'b0);
      end
      // full, then a second byte before the first is read
      for (int c = 0; c < 2; c++) begin
         host_u.wr(8'h07, nib(8'h01, c));
         send_byte(c, 8'ha5);
         ichk(1'b1);
         rchk(8'h08, nib(8'h09, c), nib(8'h0f, c));
         host_u.wr(8'h07, nib(8'h04, c));
         send_byte(c, 8'h3c);
         ichk(1'b1);
         rchk(8'h08, nib(8'h0d, c), nib(8'h0f, c));
         rchk(dat(c), 8'h3c, 8'hff);
         ichk(1'b0);
      end
      // gap zero: partial byte ends at the first invalid bit
      host_u.wr(8'h07, 8'h02);
      send_bit(0, 1'b1, 1'b1);
      send_bit(0, 1'b1, 1'b0);
      send_bit(0, 1'b1, 1'b1);
      send_bit(0, 1'b0, 1'b0);
      ichk(1'b1);
      rchk(8'h08, 8'h03, 8'h0f);
      ichk(1'b0);
      rchk(8'h09, 8'h05, 8'h07);
      // gap two: the third invalid bit ends the frame
      host_u.wr(8'h06, 8'h0a);
      host_u.wr(8'h07, 8'h20);
      send_bit(1, 1'b1, 1'b1);
      send_bit(1, 1'b0, 1'b0);
      send_bit(1, 1'b0, 1'b0);
      ichk(1'b0);
      send_bit(1, 1'b0, 1'b0);
      ichk(1'b1);
      rchk(8'h08, 8'h30, 8'hf0);
      ichk(1'b0);
      // receive invert flips every bit value of channel A
      host_u.wr(8'h05, 8'h11);
      send_byte(0, 8'h5a);
      rchk(8'h09, 8'ha5, 8'hff);
      // second reset in mid-run
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      rchk(8'h07, 8'h00, 8'hff);
      rchk(8'h06, 8'h03, 8'hff);
      stop_test();
   end
endmodule

`default_nettype wire
